// *** hdl/dams_consts.vh ***
// Purpose: constants for the dual converter mode sequencer
// Assumes: 8-bit special-function register bus on clk_sys
// Notes: included by dams_sequencer.v only
`ifndef DAMS_CONSTS_VH
`define DAMS_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define DAMS_ADDR_MODE 8'hd1
`define DAMS_ADDR_PCFG 8'hd2
`define DAMS_ADDR_ACFG 8'hd3
`define DAMS_ADDR_STAT 8'hd8

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DAMS_MODE_RST 8'h00
`define DAMS_STAT_RST 8'h00
`define DAMS_BIT_PEN 5
`define DAMS_BIT_AEN 4
`define DAMS_MD_HI 2
`define DAMS_MD_LO 0
`define DAMS_BIT_PRIMARY_READY_FLAG 7
`define DAMS_BIT_AUXILIARY_READY_FLAG 6
`define DAMS_BIT_CAL 5
`define DAMS_BIT_PRIMARY_ERROR_FLAG 3
`define DAMS_BIT_AUXILIARY_ERROR_FLAG 2
`define DAMS_BIT_XREF 6
`define DAMS_CH_HI 5
`define DAMS_CH_LO 4
`define DAMS_TEMP_CH 2'h2

// ----------------------------------------
// Mode codes and input routing
// ----------------------------------------
`define DAMS_MD_PDOWN 3'h0
`define DAMS_MD_IDLE 3'h1
`define DAMS_MD_SINGLE 3'h2
`define DAMS_MD_CONT 3'h3
`define DAMS_MD_IZS 3'h4
`define DAMS_MD_IFS 3'h5
`define DAMS_MD_SZS 3'h6
`define DAMS_MD_SFS 3'h7
`define DAMS_ROUTE_PINS 2'h0
`define DAMS_ROUTE_SHORT 2'h1
`define DAMS_ROUTE_REF 2'h2

`endif

// *** hdl/dams_sequencer.v ***
// Purpose: mode sequencer for a primary and an auxiliary sigma-delta converter
// Assumes: converter tick and clamp inputs are on clk_sys; filter settles itself
// Notes: config registers live elsewhere; this block snoops their writes
`timescale 1ns/1ps
`default_nettype none
`include "dams_consts.vh"

module dams_sequencer (
    // Clock and reset
    input wire clk_sys,
    input wire srst,
    // Special-function register bus
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata,
    // Primary converter
    input wire pri_out_tick,
    input wire pri_clamp,
    output reg pri_power_up,
    output reg pri_hold_reset,
    output reg pri_conv_reset,
    output reg [1:0] pri_route,
    output reg pri_ref_ext,
    output reg pri_result_we,
    output reg pri_coef_we,
    output reg pri_coef_gain,
    // Auxiliary converter
    input wire aux_out_tick,
    input wire aux_clamp,
    output reg aux_power_up,
    output reg aux_hold_reset,
    output reg aux_conv_reset,
    output reg [1:0] aux_route,
    output reg aux_ref_ext,
    output reg aux_result_we,
    output reg aux_coef_we,
    output reg aux_coef_gain,
    // Shared filter control
    output reg decim_force_max
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function is_cal;
        input [2:0] md;
        begin
            is_cal = md[2];
        end
    endfunction

    function is_work;
        input [2:0] md;
        begin
            is_work = (md == `DAMS_MD_SINGLE) || (md == `DAMS_MD_CONT) || md[2];
        end
    endfunction

    function [1:0] route_of;
        input [2:0] md;
        begin
            case (md)
                `DAMS_MD_IZS: route_of = `DAMS_ROUTE_SHORT;
                `DAMS_MD_IFS: route_of = `DAMS_ROUTE_REF;
                default: route_of = `DAMS_ROUTE_PINS;
            endcase
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg pri_en;
    reg aux_en;
    reg [2:0] mode;
    reg primary_ready_flag;
    reg auxiliary_ready_flag;
    reg cal_done;
    reg primary_error_flag;
    reg auxiliary_error_flag;
    reg pcfg_xref;
    reg acfg_xref;
    reg [1:0] acfg_ch;
    reg pri_got;
    reg aux_got;
    reg aux_align;

    reg next_pri_en;
    reg next_aux_en;
    reg [2:0] next_mode;
    reg next_primary_ready_flag;
    reg next_auxiliary_ready_flag;
    reg next_cal_done;
    reg next_primary_error_flag;
    reg next_auxiliary_error_flag;
    reg next_pri_got;
    reg next_aux_got;
    reg next_aux_align;
    reg rst_both;
    reg rst_aux;
    reg pri_we;
    reg aux_we;
    reg pcw;
    reg acw;

    wire wr_mode = sfr_wr && (sfr_addr == `DAMS_ADDR_MODE);
    wire wr_stat = sfr_wr && (sfr_addr == `DAMS_ADDR_STAT);
    wire wr_pcfg = sfr_wr && (sfr_addr == `DAMS_ADDR_PCFG);
    wire wr_acfg = sfr_wr && (sfr_addr == `DAMS_ADDR_ACFG);
    wire [2:0] w_md = sfr_wdata[`DAMS_MD_HI:`DAMS_MD_LO];
    wire w_pen = sfr_wdata[`DAMS_BIT_PEN];
    wire w_aen = sfr_wdata[`DAMS_BIT_AEN];

    wire [7:0] mode_rst = `DAMS_MODE_RST;
    wire pri_act = pri_en && is_work(mode);
    wire aux_act = aux_en && is_work(mode);
    wire aux_temp = (acfg_ch == `DAMS_TEMP_CH);
    wire pri_tk = pri_act && pri_out_tick;
    wire aux_tk = aux_act && aux_out_tick && !aux_align;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always @* begin
        next_pri_en = pri_en;
        next_aux_en = aux_en;
        next_mode = mode;
        next_primary_ready_flag = primary_ready_flag;
        next_auxiliary_ready_flag = auxiliary_ready_flag;
        next_cal_done = cal_done;
        next_primary_error_flag = primary_error_flag;
        next_auxiliary_error_flag = auxiliary_error_flag;
        next_pri_got = pri_got;
        next_aux_got = aux_got;
        next_aux_align = aux_align;
        rst_both = 1'b0;
        rst_aux = 1'b0;
        pri_we = 1'b0;
        aux_we = 1'b0;
        pcw = 1'b0;
        acw = 1'b0;

        // Software clears status first so a same-cycle completion still sets
        if (wr_stat) begin
            next_primary_ready_flag = sfr_wdata[`DAMS_BIT_PRIMARY_READY_FLAG];
            next_auxiliary_ready_flag = sfr_wdata[`DAMS_BIT_AUXILIARY_READY_FLAG];
            next_cal_done = sfr_wdata[`DAMS_BIT_CAL];
            next_primary_error_flag = sfr_wdata[`DAMS_BIT_PRIMARY_ERROR_FLAG];
            next_auxiliary_error_flag = sfr_wdata[`DAMS_BIT_AUXILIARY_ERROR_FLAG];
        end

        // Primary outputs realign a waiting auxiliary converter
        if (pri_act && pri_out_tick) begin
            next_aux_align = 1'b0;
        end

        // Primary completion
        if (pri_tk && !(is_cal(mode) ? pri_got : 1'b0)) begin
            if (!primary_ready_flag) begin
                if (is_cal(mode)) begin
                    pcw = 1'b1;
                end else begin
                    pri_we = 1'b1;
                    if (pri_clamp) begin
                        next_primary_error_flag = 1'b1;
                    end
                end
            end
            next_primary_ready_flag = 1'b1;
            next_pri_got = 1'b1;
        end

        // Auxiliary completion
        if (aux_tk && !(is_cal(mode) ? aux_got : 1'b0)) begin
            if (!auxiliary_ready_flag) begin
                if (is_cal(mode)) begin
                    if (aux_temp) begin
                        next_auxiliary_error_flag = 1'b1;
                    end else begin
                        acw = 1'b1;
                    end
                end else begin
                    aux_we = 1'b1;
                    if (aux_clamp) begin
                        next_auxiliary_error_flag = 1'b1;
                    end
                end
            end
            next_auxiliary_ready_flag = 1'b1;
            next_aux_got = 1'b1;
        end

        // Single and calibration end once every enabled converter finished
        if ((mode == `DAMS_MD_SINGLE || is_cal(mode)) && (pri_act || aux_act)
                && (!pri_act || next_pri_got) && (!aux_act || next_aux_got)) begin
            next_mode = `DAMS_MD_PDOWN;
            if (is_cal(mode)) begin
                next_cal_done = 1'b1;
            end
        end

        // Auxiliary-only resets
        if (wr_acfg) begin
            rst_aux = 1'b1;
        end

        // Primary config write
        if (wr_pcfg && pri_en) begin
            rst_both = 1'b1;
        end

        // Mode write wins over the self-clear above
        if (wr_mode) begin
            next_pri_en = w_pen;
            next_aux_en = w_aen;
            next_mode = w_md;
            if (w_md == mode && w_pen == pri_en && w_aen && !aux_en) begin
                rst_aux = 1'b1;
            end else begin
                rst_both = 1'b1;
            end
            if (is_work(w_md)) begin
                next_primary_error_flag = 1'b0;
                next_auxiliary_error_flag = 1'b0;
                next_cal_done = 1'b0;
            end
            if (is_cal(w_md)) begin
                next_primary_ready_flag = 1'b0;
                next_auxiliary_ready_flag = 1'b0;
            end
        end

        if (rst_both) begin
            next_pri_got = 1'b0;
            next_aux_got = 1'b0;
            next_aux_align = 1'b0;
        end else if (rst_aux) begin
            next_aux_got = 1'b0;
            // Wait for the primary cadence only when primary is running
            next_aux_align = pri_en && is_work(next_mode);
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (srst) begin
            pri_en <= mode_rst[`DAMS_BIT_PEN];
            aux_en <= mode_rst[`DAMS_BIT_AEN];
            mode <= `DAMS_MD_PDOWN;
            primary_ready_flag <= 1'b0;
            auxiliary_ready_flag <= 1'b0;
            cal_done <= 1'b0;
            primary_error_flag <= 1'b0;
            auxiliary_error_flag <= 1'b0;
            pcfg_xref <= 1'b0;
            acfg_xref <= 1'b0;
            acfg_ch <= 2'h0;
            pri_got <= 1'b0;
            aux_got <= 1'b0;
            aux_align <= 1'b0;
        end else begin
            pri_en <= next_pri_en;
            aux_en <= next_aux_en;
            mode <= next_mode;
            primary_ready_flag <= next_primary_ready_flag;
            auxiliary_ready_flag <= next_auxiliary_ready_flag;
            cal_done <= next_cal_done;
            primary_error_flag <= next_primary_error_flag;
            auxiliary_error_flag <= next_auxiliary_error_flag;
            pri_got <= next_pri_got;
            aux_got <= next_aux_got;
            aux_align <= next_aux_align;
            if (wr_pcfg) begin
                pcfg_xref <= sfr_wdata[`DAMS_BIT_XREF];
            end
            if (wr_acfg) begin
                acfg_xref <= sfr_wdata[`DAMS_BIT_XREF];
                acfg_ch <= sfr_wdata[`DAMS_CH_HI:`DAMS_CH_LO];
            end
        end
    end

    // ----------------------------------------
    // Converter controls
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (srst) begin
            pri_power_up <= 1'b0;
            aux_power_up <= 1'b0;
            pri_hold_reset <= 1'b1;
            aux_hold_reset <= 1'b1;
            pri_conv_reset <= 1'b0;
            aux_conv_reset <= 1'b0;
            pri_route <= `DAMS_ROUTE_PINS;
            aux_route <= `DAMS_ROUTE_PINS;
            pri_ref_ext <= 1'b0;
            aux_ref_ext <= 1'b0;
            pri_result_we <= 1'b0;
            aux_result_we <= 1'b0;
            pri_coef_we <= 1'b0;
            aux_coef_we <= 1'b0;
            pri_coef_gain <= 1'b0;
            aux_coef_gain <= 1'b0;
            decim_force_max <= 1'b0;
        end else begin
            pri_power_up <= next_pri_en && (next_mode != `DAMS_MD_PDOWN);
            aux_power_up <= next_aux_en && (next_mode != `DAMS_MD_PDOWN);
            // Idle keeps modulator clocked but filter held
            pri_hold_reset <= !next_pri_en || (next_mode == `DAMS_MD_IDLE);
            aux_hold_reset <= !next_aux_en || (next_mode == `DAMS_MD_IDLE);
            pri_conv_reset <= rst_both;
            aux_conv_reset <= rst_both || rst_aux;
            pri_route <= route_of(next_mode);
            aux_route <= route_of(next_mode);
            pri_ref_ext <= pcfg_xref;
            aux_ref_ext <= acfg_xref;
            pri_result_we <= pri_we;
            aux_result_we <= aux_we;
            pri_coef_we <= pcw;
            aux_coef_we <= acw;
            pri_coef_gain <= mode[0];
            aux_coef_gain <= mode[0];
            decim_force_max <= is_cal(next_mode);
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Unmapped addresses return zero; reserved bits read zero
    always @(posedge clk_sys) begin
        if (srst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd && sfr_addr == `DAMS_ADDR_MODE) begin
            sfr_rdata <= {2'h0, pri_en, aux_en, 1'b0, mode};
        end else if (sfr_rd && sfr_addr == `DAMS_ADDR_STAT) begin
            sfr_rdata <= {primary_ready_flag, auxiliary_ready_flag, cal_done, 1'b0, primary_error_flag, auxiliary_error_flag, 2'h0};
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// *** sim/dams_props.sv ***
// Purpose: port assertions for dams_sequencer
// Assumes: one clock, srst synchronous
// Notes: pen_q mirrors the primary enable
`timescale 1ns/1ps
`default_nettype none
module dams_props (
    // Clock and bus
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    // Converters
    input wire logic pri_out_tick,
    input wire logic aux_out_tick,
    input wire logic pri_power_up,
    input wire logic aux_power_up,
    input wire logic pri_hold_reset,
    input wire logic pri_conv_reset,
    input wire logic aux_conv_reset,
    input wire logic [1:0] pri_route,
    input wire logic pri_result_we,
    input wire logic aux_coef_we,
    input wire logic decim_force_max
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire mw = sfr_wr && sfr_addr == 8'hd1;
    logic [7:0] wd_q;
    logic pen_q;
    // Enables never self-clear, so a mirror of writes suffices
    always @(posedge clk_sys) begin
        wd_q <= sfr_wdata;
        if (srst) begin
            pen_q <= 1'b0;
        end else if (mw) begin
            pen_q <= sfr_wdata[5];
        end
    end
    AST_PRI_POWER: assert property (mw |=> pri_power_up == (wd_q[5] && wd_q[2:0] != 3'h0))
        else $error("primary power wrong after mode write");
    AST_AUX_POWER: assert property (mw |=> aux_power_up == (wd_q[4] && wd_q[2:0] != 3'h0))
        else $error("auxiliary power wrong after mode write");
    AST_IDLE_HOLD: assert property (mw |=> pri_hold_reset == (!wd_q[5] || wd_q[2:0] == 3'h1))
        else $error("primary hold wrong after mode write");
    AST_MODE_RESET: assert property (mw && !sfr_wdata[4] |=> pri_conv_reset && aux_conv_reset)
        else $error("mode write did not reset both");
    AST_PCFG_RESET: assert property (sfr_wr && sfr_addr == 8'hd2 && pen_q
        |=> pri_conv_reset && aux_conv_reset)
        else $error("primary config write did not reset both");
    AST_ACFG_AUX: assert property (sfr_wr && sfr_addr == 8'hd3
        |=> aux_conv_reset && !pri_conv_reset)
        else $error("auxiliary config write reset wrong side");
    AST_CAL_DECIM: assert property (mw && sfr_wdata[2] && sfr_wdata[5] |=> decim_force_max)
        else $error("calibration without max decimation");
    AST_ROUTE: assert property (mw && sfr_wdata[5] && sfr_wdata[2:1] == 2'h2
        |=> pri_route == {wd_q[0], !wd_q[0]})
        else $error("calibration route wrong");
    AST_RESULT_CAUSE: assert property (pri_result_we |-> $past(pri_out_tick))
        else $error("result store without tick");
    AST_COEF_CAUSE: assert property (aux_coef_we |-> $past(aux_out_tick) && $past(decim_force_max))
        else $error("coefficient store without calibration tick");
    cover property (mw && sfr_wdata[2]);
    cover property (pri_result_we);
    cover property (aux_coef_we);
endmodule
bind dams_sequencer dams_props dams_props_inst (.clk_sys(clk_sys), .srst(srst),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .pri_out_tick(pri_out_tick), .aux_out_tick(aux_out_tick),
    .pri_power_up(pri_power_up), .aux_power_up(aux_power_up),
    .pri_hold_reset(pri_hold_reset), .pri_conv_reset(pri_conv_reset),
    .aux_conv_reset(aux_conv_reset), .pri_route(pri_route),
    .pri_result_we(pri_result_we), .aux_coef_we(aux_coef_we),
    .decim_force_max(decim_force_max));
`default_nettype wire

// *** sim/dams_host_model.sv ***
// Purpose: processor side of the register bus
// Assumes: strobes taken at the rising edge
// Notes: drives at falling edges, one access per call
`timescale 1ns/1ps
`default_nettype none
module dams_host_model (
    // Clock
    input wire logic clk_sys,
    // Register bus
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output logic sfr_wr,
    output logic sfr_rd,
    input wire logic [7:0] sfr_rdata
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    end
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
        // Released data shows no stale value
        sfr_wdata = ~d;
    endtask
    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask
endmodule
`default_nettype wire

// *** sim/dams_sequencer_test.sv ***
// Purpose: self-checking bench for dams_sequencer
// Assumes: host model owns the bus, bench owns the ticks
// Notes: ticks and strobes change at falling edges
`timescale 1ns/1ps
`default_nettype none
module dams_sequencer_test;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic pt = 1'b0;
    logic at = 1'b0;
    logic pc = 1'b0;
    logic [5:0] seen;
    logic [7:0] cd;
    int num_errors = 0;
    int samples_checked = 0;
    wire [7:0] sa, sd, sq;
    wire sw, sr, ppu, phr, pcr, pre, pref, pcw, pcg, apu, ahr, acr, are, acw, acg, dfm, aref;
    wire [1:0] prt, art;
    initial forever #10 clk_sys = ~clk_sys;
    dams_host_model dams_host_model_inst (.clk_sys(clk_sys), .sfr_addr(sa),
        .sfr_wdata(sd), .sfr_wr(sw), .sfr_rd(sr), .sfr_rdata(sq));
    dams_sequencer dams_sequencer_inst (.clk_sys(clk_sys), .srst(srst), .sfr_addr(sa),
        .sfr_wdata(sd), .sfr_wr(sw), .sfr_rd(sr), .sfr_rdata(sq),
        .pri_out_tick(pt), .pri_clamp(pc), .pri_power_up(ppu), .pri_hold_reset(phr),
        .pri_conv_reset(pcr), .pri_route(prt), .pri_ref_ext(pref), .pri_result_we(pre),
        .pri_coef_we(pcw), .pri_coef_gain(pcg), .aux_out_tick(at), .aux_clamp(pc),
        .aux_power_up(apu), .aux_hold_reset(ahr), .aux_conv_reset(acr), .aux_route(art),
        .aux_ref_ext(aref), .aux_result_we(are), .aux_coef_we(acw), .aux_coef_gain(acg),
        .decim_force_max(dfm));
    // ----
    // Tasks
    // ----
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        dams_host_model_inst.bus_write(a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        logic [7:0] v;
        dams_host_model_inst.bus_read(a, v);
        chk(n, e, v);
    endtask
    // Store strobes are sampled in the cycle after the tick edge
    task automatic tick(input logic p, input logic a, input logic c);
        @(negedge clk_sys);
        pt = p;
        at = a;
        pc = c;
        @(negedge clk_sys);
        // Gain select only means something alongside a coefficient store
        seen = {pre, are, pcw, acw, pcw & pcg, acw & acg};
        pt = 1'b0;
        at = 1'b0;
        pc = 1'b0;
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        conclude();
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        srst = 1'b0;
        rd(8'hd1, 8'h00, "mode_rst");
        rd(8'hd8, 8'h00, "stat_rst");
        chk("hold_rst", 8'h01, {7'h0, phr});
        wr(8'hd1, 8'hc8);
        rd(8'hd1, 8'h00, "reserved");
        rd(8'h00, 8'h00, "unmapped");
        $display("test reset done");
        wr(8'hd1, 8'h22);
        chk("up", 8'h02, {6'h0, ppu, apu});
        chk("mode_rst_both", 8'h03, {6'h0, pcr, acr});
        tick(1'b1, 1'b0, 1'b0);
        chk("single_we", 8'h20, {2'h0, seen});
        rd(8'hd1, 8'h20, "single_end");
        rd(8'hd8, 8'h80, "single_rdy");
        wr(8'hd1, 8'h22);
        fork
            wr(8'hd1, 8'h23);
            tick(1'b1, 1'b0, 1'b0);
        join
        rd(8'hd1, 8'h23, "write_wins");
        $display("test single done");
        wr(8'hd8, 8'h00);
        tick(1'b1, 1'b0, 1'b0);
        chk("cont_we", 8'h20, {2'h0, seen});
        tick(1'b1, 1'b0, 1'b0);
        chk("rdy_block", 8'h00, {2'h0, seen});
        wr(8'hd8, 8'h00);
        tick(1'b1, 1'b0, 1'b1);
        chk("cont_we2", 8'h20, {2'h0, seen});
        rd(8'hd8, 8'h88, "clamp_err");
        wr(8'hd1, 8'h33);
        chk("aux_only", 8'h01, {6'h0, pcr, acr});
        wr(8'hd8, 8'h00);
        tick(1'b0, 1'b1, 1'b0);
        chk("aux_align", 8'h00, {2'h0, seen});
        tick(1'b1, 1'b0, 1'b0);
        chk("pri_runs", 8'h20, {2'h0, seen});
        tick(1'b0, 1'b1, 1'b0);
        chk("aux_step", 8'h10, {2'h0, seen});
        wr(8'hd3, 8'h40);
        chk("acfg_rst", 8'h01, {6'h0, pcr, acr});
        wr(8'hd2, 8'h40);
        chk("pcfg_rst", 8'h03, {6'h0, pcr, acr});
        // Reference select follows the snooped write one cycle later
        @(negedge clk_sys);
        chk("ref_ext", 8'h03, {6'h0, pref, aref});
        $display("test continuous done");
        // Codes 6 and 7 assume the system input is already applied
        for (cd = 8'h04; cd < 8'h08; cd++) begin
            wr(8'hd1, 8'h30 | cd);
            chk("cal_decim", 8'h01, {7'h0, dfm});
            chk("cal_route", cd == 4 ? 8'h05 : cd == 5 ? 8'h0a : 8'h00, {4'h0, prt, art});
            rd(8'hd8, 8'h00, "cal_clr");
            tick(1'b1, 1'b1, 1'b0);
            chk("cal_coef", cd[0] ? 8'h0f : 8'h0c, {2'h0, seen});
            rd(8'hd1, 8'h30, "cal_end");
            rd(8'hd8, 8'he0, "cal_stat");
        end
        wr(8'hd3, 8'h20);
        wr(8'hd1, 8'h14);
        tick(1'b0, 1'b1, 1'b0);
        chk("temp_cal", 8'h00, {2'h0, seen});
        rd(8'hd8, 8'h64, "temp_stat");
        wr(8'hd1, 8'h12);
        rd(8'hd8, 8'h40, "err_clr");
        wr(8'hd1, 8'h21);
        chk("idle", 8'h07, {5'h0, ppu, phr, ahr});
        $display("test calibration done");
        conclude();
    end
endmodule
`default_nettype wire
